// *** hdl/mfh_device.sv ***
// Controller end of the host port: cycle decode, read mux, output latch, mask and interrupt register.
// Assumes the host end shares clk_in; pin inputs arrive asynchronously and are synchronised.
`timescale 1ns/1ns
module mfh_device
	import mfh_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	mfh_bus_if.dev           bus,
	input  wire logic [7:0]  direct_input_pins_in,
	output logic      [7:0]  inverted_output_pins_out,
	input  wire logic        serial_rx_line_in,
	output logic             serial_tx_line_out,
	input  wire logic        sensor_edge_input_in,
	input  wire logic        tx_shift_busy_in,
	input  wire logic        tx_shift_bit_in,
	input  wire logic [7:0]  rx_buffer_in,
	input  wire logic [7:0]  status_in,
	input  wire logic [7:0]  irq_set_in,
	output logic             rx_start_out,
	output logic             rx_buffer_read_out,
	output logic             cmd_strobe_out,
	output logic      [3:0]  cmd_func_out,
	output logic      [7:0]  cmd_data_out
);
	logic       rx_meta_q, rx_sync_q, rx_prev_q;
	logic       sensor_edge_input_meta_q, sensor_edge_input_sync_q, sensor_edge_input_prev_q;
	logic [7:0] xi_meta_q, xi_sync_q;
	logic       act_q;
	logic [3:0] func_q;
	logic       inta_q, wr_q;
	logic [7:0] rd_q;
	logic [2:0] rd_idx_q;
	logic [7:0] out_q, mask_q, irq_q, irq_d;
	logic       ack_en_q;
	logic [7:0] masked;
	logic [2:0] top_idx;
	logic [7:0] rst_code;
	logic       sensor_edge_input_rise, rx_fall;
	logic       wr_fire, rd_fire, int_clear;
	logic       disc_reset;

	// Lowest index of the masked requests wins
	function automatic logic [2:0] mfh_top(input logic [7:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = IRQ_W - 1; i >= 0; i--)
		begin
			if (req[i])
				idx = 3'(i);
		end
		return idx;
	endfunction

	// Two-flop synchronisers and edge history for pins
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			rx_meta_q   <= 1'b1;
			rx_sync_q   <= 1'b1;
			rx_prev_q   <= 1'b1;
			sensor_edge_input_meta_q <= 1'b0;
			sensor_edge_input_sync_q <= 1'b0;
			sensor_edge_input_prev_q <= 1'b0;
			xi_meta_q   <= 8'h00;
			xi_sync_q   <= 8'h00;
		end
		else
		begin
			rx_meta_q   <= serial_rx_line_in;
			rx_sync_q   <= rx_meta_q;
			rx_prev_q   <= rx_sync_q;
			sensor_edge_input_meta_q <= sensor_edge_input_in;
			sensor_edge_input_sync_q <= sensor_edge_input_meta_q;
			sensor_edge_input_prev_q <= sensor_edge_input_sync_q;
			xi_meta_q   <= direct_input_pins_in;
			xi_sync_q   <= xi_meta_q;
		end
	end

	assign sensor_edge_input_rise = sensor_edge_input_sync_q & ~sensor_edge_input_prev_q;
	assign rx_fall   = rx_prev_q & ~rx_sync_q;

	// Receiver start pulse toward the serial receiver
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			rx_start_out <= 1'b0;
		else
			rx_start_out <= rx_fall;
	end

	// Priority and restart instruction
	assign masked   = irq_q & mask_q;
	assign top_idx  = mfh_top(masked);
	assign rst_code = {RST_HIGH_BITS, top_idx, RST_LOW_BITS};

	// Cycle capture while the marker is high and the chip is selected
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			act_q    <= 1'b0;
			func_q   <= 4'h0;
			inta_q   <= 1'b0;
			wr_q     <= 1'b0;
			rd_idx_q <= 3'h0;
		end
		else
		begin
			act_q <= bus.sync & bus.cs;
			if (bus.sync & bus.cs)
			begin
				func_q   <= bus.addr;
				inta_q   <= bus.data[ST_INTA_BIT];
				wr_q     <= bus.data[ST_OUTCYC_BIT];
				rd_idx_q <= top_idx;
			end
		end
	end

	// Read data prepared at the marker edge
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			rd_q <= 8'h00;
		else if (bus.sync & bus.cs)
		begin
			if (bus.data[ST_INTA_BIT])
				rd_q <= rst_code;
			else
			begin
				case (bus.addr)
					FN_READ_RXBUF:   rd_q <= rx_buffer_in;
					FN_READ_INPUTS:  rd_q <= xi_sync_q;
					FN_READ_INTADDR: rd_q <= rst_code;
					FN_READ_STATUS:
					begin
						rd_q                   <= status_in;
						rd_q[STAT_RXLINE_BIT]  <= rx_sync_q;
						rd_q[STAT_INTPEND_BIT] <= |masked;
					end
					default:         rd_q <= 8'h00;
				endcase
			end
		end
	end

	// Bus drive only in the data phase of a selected read
	assign rd_fire    = act_q & bus.cs & ~wr_q &
		(inta_q ? ack_en_q : (func_q <= FN_READ_STATUS));
	assign bus.dev_oe = rd_fire;
	assign bus.dev_d  = rd_q;

	// Write phase decode; codes above the last command do nothing
	assign wr_fire    = act_q & bus.cs & wr_q & ~inta_q & (func_q <= FN_LAST_CMD);
	assign disc_reset = wr_fire & (func_q == FN_DISCRETE) & bus.data[DC_RESET_BIT];
	assign int_clear  = rd_fire & (inta_q | (func_q == FN_READ_INTADDR));

	// Output latch, complemented onto the pins
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			out_q <= OUTREG_RESET;
		else if (wr_fire & (func_q == FN_LOAD_OUTPUT))
			out_q <= bus.data;
	end

	assign inverted_output_pins_out = ~out_q;

	// Mask register and acknowledge enable
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			mask_q   <= MASK_RESET;
			ack_en_q <= 1'b0;
		end
		else
		begin
			if (wr_fire & (func_q == FN_LOAD_MASK))
				mask_q <= bus.data;
			if (wr_fire & (func_q == FN_DISCRETE))
				ack_en_q <= bus.data[DC_ACKEN_BIT];
		end
	end

	// Interrupt register next value; new events win over clears
	always_comb
	begin
		irq_d = irq_q;
		if (int_clear)
			irq_d[rd_idx_q] = 1'b0;
		if (disc_reset)
		begin
			irq_d                  = IRQ_RESET;
			irq_d[IRQ_TXEMPTY_BIT] = 1'b1;
		end
		irq_d                 = irq_d | irq_set_in;
		irq_d[IRQ_SENSOR_BIT] = irq_d[IRQ_SENSOR_BIT] | sensor_edge_input_rise;
	end

	// Interrupt register
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			irq_q <= IRQ_RESET;
		else
			irq_q <= irq_d;
	end

	assign bus.int_line = |masked;

	// Transmit line idles high outside a character
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			serial_tx_line_out <= 1'b1;
		else
			serial_tx_line_out <= tx_shift_busy_in ? tx_shift_bit_in : 1'b1;
	end

	// Command strobes for every executed write code, local ones included, and the receive buffer read pulse
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			cmd_strobe_out     <= 1'b0;
			cmd_func_out       <= 4'h0;
			cmd_data_out       <= 8'h00;
			rx_buffer_read_out <= 1'b0;
		end
		else
		begin
			cmd_strobe_out     <= wr_fire;
			rx_buffer_read_out <= rd_fire & ~inta_q & (func_q == FN_READ_RXBUF);
			if (wr_fire)
			begin
				cmd_func_out <= func_q;
				cmd_data_out <= bus.data;
			end
		end
	end
endmodule

// *** common/mfh_pkg.sv ***
// Constants shared by both ends of the host port: function codes, bit positions, reset values.
// Assumes both ends run on one clock, clk_in, at 125 MHz.
package mfh_pkg;
	localparam int          DATA_W           = 8;
	localparam int          FUNC_W           = 4;
	localparam int          IRQ_W            = 8;
	// Function codes on the address lines
	localparam logic [3:0]  FN_READ_RXBUF    = 4'h0;
	localparam logic [3:0]  FN_READ_INPUTS   = 4'h1;
	localparam logic [3:0]  FN_READ_INTADDR  = 4'h2;
	localparam logic [3:0]  FN_READ_STATUS   = 4'h3;
	localparam logic [3:0]  FN_DISCRETE      = 4'h4;
	localparam logic [3:0]  FN_LOAD_OUTPUT   = 4'h7;
	localparam logic [3:0]  FN_LOAD_MASK     = 4'h8;
	localparam logic [3:0]  FN_LAST_CMD      = 4'hD;
	// Status bits sampled while the cycle marker is high
	localparam int          ST_INTA_BIT      = 0;
	localparam int          ST_OUTCYC_BIT    = 1;
	// Discrete command bits
	localparam int          DC_RESET_BIT     = 0;
	localparam int          DC_ACKEN_BIT     = 3;
	// Interrupt sources and restart instruction layout
	localparam int          IRQ_SENSOR_BIT   = 2;
	localparam int          IRQ_TXEMPTY_BIT  = 5;
	localparam logic [1:0]  RST_HIGH_BITS    = 2'h3;
	localparam logic [2:0]  RST_LOW_BITS     = 3'h7;
	// Status register bit positions owned by this block
	localparam int          STAT_RXLINE_BIT  = 2;
	localparam int          STAT_INTPEND_BIT = 5;
	// Reset values and idle bus level
	localparam logic [7:0]  OUTREG_RESET     = 8'h00;
	localparam logic [7:0]  MASK_RESET       = 8'h00;
	localparam logic [7:0]  IRQ_RESET        = 8'h00;
	localparam logic [7:0]  BUS_IDLE_LEVEL   = 8'hFF;
endpackage

// *** common/mfh_bus_if.sv ***
// Host bus between the processor end and the I/O controller end.
// Assumes one clock; the shared data bus is resolved here from the two output enables.
`timescale 1ns/1ns
interface mfh_bus_if;
	logic       cs;
	logic [3:0] addr;
	logic       sync;
	logic [7:0] host_d;
	logic       host_oe;
	logic [7:0] dev_d;
	logic       dev_oe;
	logic       int_line;
	logic [7:0] data;

	// Bus level: device drive first, then host, else pulled-up idle
	assign data = dev_oe ? dev_d : (host_oe ? host_d : mfh_pkg::BUS_IDLE_LEVEL);

	modport host (
		output cs,
		output addr,
		output sync,
		output host_d,
		output host_oe,
		input  data,
		input  int_line
	);

	modport dev (
		input  cs,
		input  addr,
		input  sync,
		output dev_d,
		output dev_oe,
		input  data,
		output int_line
	);
endinterface

// *** hdl/mfh_host.sv ***
// Processor end of the host port: runs one marker cycle then one data cycle per request.
// Assumes the controller end shares clk_in and answers in the data cycle.
`timescale 1ns/1ns
module mfh_host
	import mfh_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	mfh_bus_if.host          bus,
	input  wire logic        req_in,
	input  wire logic        write_in,
	input  wire logic        inta_in,
	input  wire logic [3:0]  func_in,
	input  wire logic [7:0]  wdata_in,
	output logic             ready_out,
	output logic      [7:0]  rdata_out,
	output logic             done_out,
	output logic             irq_out
);
	typedef enum logic [1:0] {HS_IDLE, HS_SYNC, HS_XFER} mfh_hstate_t;

	mfh_hstate_t state_q;
	logic        cs_q, sync_q, oe_q, wr_q;
	logic [3:0]  addr_q;
	logic [7:0]  d_q, wdata_q;

	assign bus.cs      = cs_q;
	assign bus.addr    = addr_q;
	assign bus.sync    = sync_q;
	assign bus.host_d  = d_q;
	assign bus.host_oe = oe_q;
	assign ready_out   = (state_q == HS_IDLE);
	assign irq_out     = bus.int_line;

	// Cycle sequencer
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state_q   <= HS_IDLE;
			cs_q      <= 1'b0;
			sync_q    <= 1'b0;
			oe_q      <= 1'b0;
			wr_q      <= 1'b0;
			addr_q    <= 4'h0;
			d_q       <= 8'h00;
			wdata_q   <= 8'h00;
			rdata_out <= 8'h00;
			done_out  <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			case (state_q)
				HS_IDLE:
				begin
					if (req_in)
					begin
						cs_q                <= 1'b1;
						addr_q              <= func_in;
						sync_q              <= 1'b1;
						oe_q                <= 1'b1;
						d_q                 <= 8'h00;
						d_q[ST_INTA_BIT]    <= inta_in;
						d_q[ST_OUTCYC_BIT]  <= write_in & ~inta_in;
						wr_q                <= write_in & ~inta_in;
						wdata_q             <= wdata_in;
						state_q             <= HS_SYNC;
					end
				end
				HS_SYNC:
				begin
					sync_q  <= 1'b0;
					oe_q    <= wr_q;
					d_q     <= wdata_q;
					state_q <= HS_XFER;
				end
				HS_XFER:
				begin
					if (!wr_q)
						rdata_out <= bus.data;
					done_out <= 1'b1;
					cs_q     <= 1'b0;
					oe_q     <= 1'b0;
					state_q  <= HS_IDLE;
				end
				default:
				begin
					cs_q    <= 1'b0;
					sync_q  <= 1'b0;
					oe_q    <= 1'b0;
					state_q <= HS_IDLE;
				end
			endcase
		end
	end
endmodule

// *** verification/mfh_properties.sv ***
// Checker for the host bus between the two ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module mfh_properties (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       cs_in,
	input wire logic [3:0] addr_in,
	input wire logic       sync_in,
	input wire logic       host_oe_in,
	input wire logic [7:0] dev_d_in,
	input wire logic       dev_oe_in,
	input wire logic       int_line_in,
	input wire logic [7:0] data_in
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Bus drive only inside selected read cycles
	AST_DRIVE_NEEDS_CS: assert property (dev_oe_in |-> cs_in)
		else $error("controller drove bus while not selected");
	AST_DRIVE_AFTER_MARK: assert property (dev_oe_in |-> $past(sync_in))
		else $error("controller drove bus without a marker cycle");
	AST_READ_ANSWERED: assert property (sync_in && cs_in && data_in[1:0] == 2'h0 && addr_in <= 4'h3 |=> dev_oe_in)
		else $error("read code not answered");
	AST_WRITE_SILENT: assert property (sync_in && cs_in && data_in[1] |=> !dev_oe_in)
		else $error("controller drove bus in output cycle");
	AST_NOFUNC_SILENT: assert property (sync_in && cs_in && addr_in >= 4'hE |=> !dev_oe_in)
		else $error("unused code drove bus");
	AST_NO_CONTENTION: assert property (!(dev_oe_in && host_oe_in))
		else $error("both ends drove bus");
	AST_RESTART_FORM: assert property (dev_oe_in && $past(sync_in && data_in[0]) |->
		dev_d_in[7:6] == 2'h3 && dev_d_in[2:0] == 3'h7)
		else $error("restart byte malformed");
	AST_MARK_ONE_CYCLE: assert property (sync_in |=> !sync_in)
		else $error("marker longer than one cycle");
	AST_OE_ONE_CYCLE: assert property (dev_oe_in |=> !dev_oe_in)
		else $error("bus drive longer than one cycle");

	// Main traffic kinds
	cover property (sync_in && cs_in && !data_in[1]);
	cover property (sync_in && cs_in && data_in[1]);
	cover property (dev_oe_in && $past(data_in[0]));
	cover property ($rose(int_line_in));
endmodule

// *** verification/tb_mfio_host_and_pin_interface.sv ***
// Testbench joining the host end and the controller end over the bus interface.
// Assumes both ends share clk_in at 125 MHz with synchronous active-low reset.
`timescale 1ns/1ns
module tb_mfio_host_and_pin_interface;
	import mfh_pkg::*;
	logic       clk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       req, wr, inta, ready, done, irq, busy, txbit, rxl, sensor_edge_input, rxs, stb, txl, rbr;
	logic [3:0] func, cfn;
	logic [7:0] wd, rd, pins, opins, dseen, cdat;
	int         failures = 0;
	int         tests_run = 0;
	int         nstb = 0;
	int         nrx = 0;

	always #4 clk_in = ~clk_in;

	mfh_bus_if bus ();
	mfh_host mfh_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus), .req_in(req), .write_in(wr),
		.inta_in(inta), .func_in(func), .wdata_in(wd), .ready_out(ready), .rdata_out(rd), .done_out(done),
		.irq_out(irq));
	mfh_device mfh_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus), .direct_input_pins_in(pins),
		.inverted_output_pins_out(opins), .serial_rx_line_in(rxl), .serial_tx_line_out(txl),
		.sensor_edge_input_in(sensor_edge_input), .tx_shift_busy_in(busy), .tx_shift_bit_in(txbit), .rx_buffer_in(8'h3C),
		.status_in(8'h00), .irq_set_in(8'h00), .rx_start_out(rxs), .rx_buffer_read_out(rbr),
		.cmd_strobe_out(stb), .cmd_func_out(cfn), .cmd_data_out(cdat));
	mfh_properties mfh_properties_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_in(bus.cs),
		.addr_in(bus.addr), .sync_in(bus.sync), .host_oe_in(bus.host_oe), .dev_d_in(bus.dev_d),
		.dev_oe_in(bus.dev_oe), .int_line_in(bus.int_line), .data_in(bus.data));

	// Pulse counts and the last byte the controller put on the bus
	always @(posedge clk_in)
	begin
		nstb <= nstb + int'(stb);
		nrx <= nrx + int'(rxs);
		if (bus.dev_oe)
			dseen <= bus.data;
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// One host transfer; answer must come exactly two edges after the request is taken
	task automatic op(input logic w, input logic a, input logic [3:0] f, input logic [7:0] d);
		int i;
		i = 0;
		wait_clk(1);
		while (ready !== 1'b1 && i < 20)
		begin
			wait_clk(1);
			i++;
		end
		req = 1'b1;
		wr = w;
		inta = a;
		func = f;
		wd = d;
		wait_clk(1);
		req = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 8)
		begin
			wait_clk(1);
			i++;
		end
		check("latency", 8'h02, 8'(i));
	endtask

	task automatic t_reset();
		check("pins", 8'hFF, opins);
		check("tx", 8'h01, {7'h0, txl});
		check("irq", 8'h00, {7'h0, irq});
		$display("test reset done");
	endtask

	task automatic t_inputs();
		logic [7:0] p [4] = '{8'hA5, 8'h3C, 8'h01, 8'h80};
		foreach (p[k])
		begin
			pins = p[k];
			wait_clk(3);
			op(0, 0, FN_READ_INPUTS, 8'h00);
			check("inputs", p[k], rd);
			check("bus", p[k], dseen);
		end
		op(0, 0, FN_READ_RXBUF, 8'h00);
		check("rx buffer", 8'h3C, rd);
		check("rx buffer read", 8'h01, {7'h0, rbr});
		$display("test inputs done");
	endtask

	task automatic t_outputs();
		int s;
		op(1, 0, FN_LOAD_OUTPUT, 8'h5A);
		check("pins", 8'hA5, opins);
		wait_clk(1);
		s = nstb;
		op(1, 0, 4'hE, 8'hFF);
		op(1, 0, 4'hF, 8'h00);
		wait_clk(1);
		check("nofunc", 8'h00, 8'(nstb - s));
		op(0, 0, 4'hE, 8'h00);
		check("nofunc rd", BUS_IDLE_LEVEL, rd);
		op(0, 0, FN_LOAD_OUTPUT, 8'h00);
		check("write code rd", BUS_IDLE_LEVEL, rd);
		op(1, 0, FN_LOAD_MASK, 8'h00);
		check("func", {4'h0, FN_LOAD_MASK}, {4'h0, cfn});
		wait_clk(1);
		check("strobe", 8'h01, 8'(nstb - s));
		check("hold", 8'hA5, opins);
		$display("test outputs done");
	endtask

	task automatic t_irq();
		op(0, 1, 4'h0, 8'h00);
		check("ack off", BUS_IDLE_LEVEL, rd);
		sensor_edge_input = 1'b1;
		wait_clk(6);
		check("masked", 8'h00, {7'h0, irq});
		op(1, 0, FN_LOAD_MASK, 8'h04);
		wait_clk(1);
		check("irq", 8'h01, {7'h0, irq});
		op(0, 0, FN_READ_STATUS, 8'h00);
		check("status", 8'h24, rd);
		op(1, 0, FN_DISCRETE, 8'h08);
		check("cmd data", 8'h08, cdat);
		op(0, 1, 4'h0, 8'h00);
		check("restart", 8'hD7, rd);
		wait_clk(1);
		check("cleared", 8'h00, {7'h0, irq});
		op(1, 0, FN_LOAD_MASK, 8'h20);
		op(1, 0, FN_DISCRETE, 8'h09);
		wait_clk(1);
		check("reset irq", 8'h01, {7'h0, irq});
		op(0, 0, FN_READ_INTADDR, 8'h00);
		check("int addr", 8'hEF, rd);
		wait_clk(1);
		check("addr clear", 8'h00, {7'h0, irq});
		sensor_edge_input = 1'b0;
		$display("test interrupt done");
	endtask

	task automatic t_serial();
		int s;
		s = nrx;
		rxl = 1'b0;
		wait_clk(8);
		check("rx start", 8'h01, 8'(nrx - s));
		rxl = 1'b1;
		busy = 1'b1;
		txbit = 1'b0;
		wait_clk(2);
		check("tx bit", 8'h00, {7'h0, txl});
		busy = 1'b0;
		wait_clk(2);
		check("tx idle", 8'h01, {7'h0, txl});
		$display("test serial done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		req = 1'b0;
		wr = 1'b0;
		inta = 1'b0;
		func = 4'h0;
		wd = 8'h00;
		pins = 8'h00;
		busy = 1'b0;
		txbit = 1'b1;
		rxl = 1'b1;
		sensor_edge_input = 1'b0;
		wait_clk(8);
		rst_n_in = 1'b1;
		t_reset();
		t_inputs();
		t_outputs();
		t_irq();
		t_serial();
		finish_test();
	end

	// Watchdog far beyond the roughly 120 cycles the tests need
	initial
	begin
		#100000;
		failures++;
		finish_test();
	end
endmodule
